// ==== design/reset_seq_map.vh ====
`ifndef RESET_SEQ_MAP_VH
`define RESET_SEQ_MAP_VH

// ******************************************************************
// Timing counts
// ******************************************************************
// Internal clocks from reset cause gone to internal reset release
`define RELEASE_CYCLES      16
// Width of the release counter
`define RELEASE_CNT_W       5
// Power-on reset hold, in clocks after the power-on cell lets go
`define POR_CYCLES          8
// Width of the power-on counter
`define POR_CNT_W           4

// ******************************************************************
// Pull-up disable register field positions
// ******************************************************************
`define PUDR_WIDTH          8
`define PUDR_RESET_BIT      0
`define PUDR_RESET_VALUE    8'h00

`endif

// ==== design/sync_chain.v ====
`timescale 1ns/1ns
`include "reset_seq_map.vh"

// Two-stage synchroniser for one asynchronous level
module sync_chain
#(
   parameter RESET_VALUE = 1'b0
)
(
   input  wire clk_i,
   input  wire rst_n_i,
   input  wire d_i,
   output wire q_o
);

   reg stage1_reg;
   reg stage2_reg;

   // ***************************************************************
   // Synchroniser stages
   // ***************************************************************
   // First stage read only by the second
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         stage1_reg <= RESET_VALUE;
         stage2_reg <= RESET_VALUE;
      end
      else
      begin
         stage1_reg <= d_i;
         stage2_reg <= stage1_reg;
      end
   end

   assign q_o = stage2_reg;

endmodule // sync_chain

// ==== design/chip_reset_input_output.v ====
`timescale 1ns/1ns
`include "reset_seq_map.vh"

// Summary of operation
// - Low external reset pin initialises and holds the device in reset.
// - Internal reset releases on the clock after a fixed clock count.
// - Reset pin alone resets the core, never the test-port logic.
// - Power-on reset asserts at power-up regardless of the reset pin.
// - Writing one to the reset pull-up disable bit turns the pull-up off.
// - Reset output pin follows the internal reset state continuously.
module chip_reset_input_output
#(
   parameter RELEASE_CYCLES = `RELEASE_CYCLES,
   parameter POR_CYCLES     = `POR_CYCLES
)
(
   input  wire                   CLK_I,
   input  wire                   RESETN_I,
   input  wire                   POR_N_I,
   input  wire                   RESET_PIN_N_I,
   input  wire                   TEST_RESET_N_I,
   input  wire                   PUDR_WR_I,
   input  wire [`PUDR_WIDTH-1:0] PUDR_WDATA_I,
   output reg                    CORE_RESET_N_O,
   output reg                    TEST_RESET_N_O,
   output reg                    RESET_STATE_OUTPUT_O,
   output reg                    RESET_PULLUP_EN_O,
   output reg  [`PUDR_WIDTH-1:0] PULLUP_DISABLE_REGISTER_O
);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   // Synchronised copies of the block reset and the pins
   wire                      sys_rst_n;
   wire                      por_n_sync;
   wire                      pin_n_sync;
   wire                      test_n_sync;

   // Power-on reset stretch state
   reg  [`POR_CNT_W-1:0]     por_cnt_reg;
   reg  [`POR_CNT_W-1:0]     por_cnt_next;
   reg                       por_active_reg;

   // Release counter and internal reset state
   reg  [`RELEASE_CNT_W-1:0] rel_cnt_reg;
   reg  [`RELEASE_CNT_W-1:0] rel_cnt_next;
   reg                       core_rst_reg;
   reg                       core_rst_next;
   wire                      reset_request;

   // Pull-up disable bits
   reg  [`PUDR_WIDTH-1:0]    pudr_reg;

   // ***************************************************************
   // Derived constants
   // ***************************************************************
   // Terminal counts, worked out wide then cut to counter width
   localparam [31:0]               REL_LAST_W = RELEASE_CYCLES - 1;
   localparam [31:0]               POR_LAST_W = POR_CYCLES - 1;
   localparam [`RELEASE_CNT_W-1:0] REL_LAST   =
      REL_LAST_W[`RELEASE_CNT_W-1:0];
   localparam [`POR_CNT_W-1:0]     POR_LAST   =
      POR_LAST_W[`POR_CNT_W-1:0];
   // One-count steps at counter width
   localparam [`RELEASE_CNT_W-1:0] REL_STEP   =
      {{(`RELEASE_CNT_W-1){1'b0}}, 1'b1};
   localparam [`POR_CNT_W-1:0]     POR_STEP   =
      {{(`POR_CNT_W-1){1'b0}}, 1'b1};

   // ***************************************************************
   // Synchronisers
   // ***************************************************************
   // Block reset released through two flip-flops
   sync_chain #(.RESET_VALUE(1'b0)) u_sys_rst
   (
      .clk_i   (CLK_I),
      .rst_n_i (RESETN_I),
      .d_i     (1'b1),
      .q_o     (sys_rst_n)
   );

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   // Power-on cell, asserted at power-up
   sync_chain #(.RESET_VALUE(1'b0)) u_por
   (
      .clk_i   (CLK_I),
      .rst_n_i (sys_rst_n),
      .d_i     (POR_N_I),
      .q_o     (por_n_sync)
   );

   // External reset pin
   sync_chain #(.RESET_VALUE(1'b0)) u_pin
   (
      .clk_i   (CLK_I),
      .rst_n_i (sys_rst_n),
      .d_i     (RESET_PIN_N_I),
      .q_o     (pin_n_sync)
   );

   // Test-port reset, independent of the device reset pin
   sync_chain #(.RESET_VALUE(1'b0)) u_test
   (
      .clk_i   (CLK_I),
      .rst_n_i (sys_rst_n),
      .d_i     (TEST_RESET_N_I),
      .q_o     (test_n_sync)
   );

   // ***************************************************************
   // Power-on reset stretch
   // ***************************************************************
   // Count next value
   always @*
   begin
      por_cnt_next = por_cnt_reg;
      if (!por_n_sync)
         por_cnt_next = {`POR_CNT_W{1'b0}};
      else if (por_active_reg)
         por_cnt_next = por_cnt_reg + POR_STEP;
   end

   // Power-on active from power-up until count done
   // Counter parks one past the last value until the cell drops again
   always @(posedge CLK_I or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
      begin
         por_cnt_reg    <= {`POR_CNT_W{1'b0}};
         por_active_reg <= 1'b1;
      end
      else
      begin
         por_cnt_reg <= por_cnt_next;
         if (!por_n_sync)
            por_active_reg <= 1'b1;
         else if (por_cnt_reg == POR_LAST)
            por_active_reg <= 1'b0;
      end
   end

   // ***************************************************************
   // Core reset sequencing
   // ***************************************************************
   // Request is pin OR power-on
   assign reset_request = !pin_n_sync || por_active_reg;

   // Hold during request, then count before release
   always @*
   begin
      rel_cnt_next  = rel_cnt_reg;
      core_rst_next = core_rst_reg;
      if (reset_request)
      begin
         rel_cnt_next  = {`RELEASE_CNT_W{1'b0}};
         core_rst_next = 1'b1;
      end
      else if (core_rst_reg)
      begin
         if (rel_cnt_reg == REL_LAST)
            core_rst_next = 1'b0;
         else
            rel_cnt_next = rel_cnt_reg + REL_STEP;
      end
   end

   // Release counter and reset state
   always @(posedge CLK_I or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
      begin
         rel_cnt_reg  <= {`RELEASE_CNT_W{1'b0}};
         core_rst_reg <= 1'b1;
      end
      else
      begin
         rel_cnt_reg  <= rel_cnt_next;
         core_rst_reg <= core_rst_next;
      end
   end

   // ***************************************************************
   // Pull-up disable register
   // ***************************************************************
   // Software write, cleared by core reset so pull-up is on after it
   always @(posedge CLK_I or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
         pudr_reg <= `PUDR_RESET_VALUE;
      else if (core_rst_reg)
         pudr_reg <= `PUDR_RESET_VALUE;
      else if (PUDR_WR_I)
         pudr_reg <= PUDR_WDATA_I;
   end

   // ***************************************************************
   // Output registers
   // ***************************************************************
   // All outputs straight from flip-flops
   always @(posedge CLK_I or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
      begin
         CORE_RESET_N_O            <= 1'b0;
         TEST_RESET_N_O            <= 1'b0;
         RESET_STATE_OUTPUT_O      <= 1'b1;
         RESET_PULLUP_EN_O         <= 1'b1;
         PULLUP_DISABLE_REGISTER_O <= `PUDR_RESET_VALUE;
      end
      else
      begin
         CORE_RESET_N_O            <= !core_rst_reg;
         TEST_RESET_N_O            <= test_n_sync;
         RESET_STATE_OUTPUT_O      <= core_rst_reg;
         RESET_PULLUP_EN_O         <= !pudr_reg[`PUDR_RESET_BIT];
         PULLUP_DISABLE_REGISTER_O <= pudr_reg;
      end
   end

endmodule // chip_reset_input_output

// ==== verif/chip_reset_input_output_monitor.sv ====
`timescale 1ns/1ns
module chip_reset_input_output_monitor
(
   input wire       CLK_I,
   input wire       RESETN_I,
   input wire       POR_N_I,
   input wire       RESET_PIN_N_I,
   input wire       TEST_RESET_N_I,
   input wire       PUDR_WR_I,
   input wire [7:0] PUDR_WDATA_I,
   input wire       CORE_RESET_N_O,
   input wire       TEST_RESET_N_O,
   input wire       RESET_STATE_OUTPUT_O,
   input wire       RESET_PULLUP_EN_O,
   input wire [7:0] PULLUP_DISABLE_REGISTER_O
);
// ***************************************
// Reset sequencing and pull-up register checks
// ***************************************
default clocking @(posedge CLK_I); endclocking
default disable iff (!RESETN_I);
// Write launched while core stays out of reset / in reset
sequence s_wr_live;
   PUDR_WR_I && CORE_RESET_N_O ##1 CORE_RESET_N_O ##1 CORE_RESET_N_O;
endsequence
sequence s_wr_dead;
   PUDR_WR_I ##1 !CORE_RESET_N_O ##1 1'b1;
endsequence
a_pin_enters: assert property ($fell(RESET_PIN_N_I) |-> ##[1:5] !CORE_RESET_N_O)
   else $error("core reset missed pin");
a_release_wait: assert property ($rose(CORE_RESET_N_O) |-> $past(RESET_PIN_N_I, 16))
   else $error("core released early");
a_por_enters: assert property ($fell(POR_N_I) |-> ##[1:5] !CORE_RESET_N_O)
   else $error("core reset missed power-on");
a_test_kept: assert property (TEST_RESET_N_I [*8] |-> TEST_RESET_N_O)
   else $error("test reset without cause");
a_test_low: assert property (!TEST_RESET_N_I [*5] |-> !TEST_RESET_N_O)
   else $error("test reset not applied");
a_state_on: assert property (!CORE_RESET_N_O |-> RESET_STATE_OUTPUT_O)
   else $error("reset output low in reset");
a_state_off: assert property (CORE_RESET_N_O |-> !RESET_STATE_OUTPUT_O)
   else $error("reset output high out of reset");
a_pullup_bit: assert property (RESET_PULLUP_EN_O == !PULLUP_DISABLE_REGISTER_O[0])
   else $error("pull-up enable wrong");
a_wr_taken: assert property (s_wr_live |-> PULLUP_DISABLE_REGISTER_O == $past(PUDR_WDATA_I, 2))
   else $error("register write lost");
a_wr_refused: assert property (s_wr_dead |-> PULLUP_DISABLE_REGISTER_O == 8'h00)
   else $error("register written in reset");
endmodule // chip_reset_input_output_monitor

bind chip_reset_input_output chip_reset_input_output_monitor i_mon (.*);

// ==== verif/reset_source.sv ====
`timescale 1ns/1ns
// External reset source and debug controller, lines idle high
module reset_source
(
   input  wire clk_i,
   input  wire pin_req_i,
   input  wire trst_req_i,
   output reg  pin_n_o  = 1'b1,
   output reg  trst_n_o = 1'b1
);
always @(posedge clk_i)
begin
   pin_n_o  <= !pin_req_i;
   trst_n_o <= !trst_req_i;
end
endmodule // reset_source

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
module testbench;
// ***************************************
// Stimulus and checks
// ***************************************
reg        clk = 1'b0;
reg        rst_n = 1'b0;
reg        por_n = 1'b0;
reg        pin_req = 1'b0;
reg        trst_req = 1'b0;
reg        wr = 1'b0;
reg  [7:0] wd = 8'h00;
wire       pin_n, trst_n, core_n, test_n, state, pu_en;
wire [7:0] pudr;
integer    fails = 0;
integer    checks = 0;
integer    n;
always #50 clk = !clk;
reset_source i_reset_source (.clk_i(clk), .pin_req_i(pin_req),
   .trst_req_i(trst_req), .pin_n_o(pin_n), .trst_n_o(trst_n));
chip_reset_input_output i_chip_reset_input_output (.CLK_I(clk),
   .RESETN_I(rst_n), .POR_N_I(por_n), .RESET_PIN_N_I(pin_n),
   .TEST_RESET_N_I(trst_n), .PUDR_WR_I(wr), .PUDR_WDATA_I(wd),
   .CORE_RESET_N_O(core_n), .TEST_RESET_N_O(test_n),
   .RESET_STATE_OUTPUT_O(state), .RESET_PULLUP_EN_O(pu_en),
   .PULLUP_DISABLE_REGISTER_O(pudr));
task finish_test;
   if (fails == 0 && checks > 0)
      $display("*** PASS ***");
   else
      $display("*** FAIL ***");
   $finish;
endtask
task chk(input string nm, input [7:0] exp, input [7:0] got);
   checks = checks + 1;
   if (got !== exp)
   begin
      fails = fails + 1;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
   end
endtask
// Bounded wait for core reset release
task wait_core;
   n = 0;
   while (core_n !== 1'b1 && n < 60)
   begin
      @(negedge clk);
      n = n + 1;
   end
   chk("release", 8'h01, {7'h00, core_n});
   if (core_n !== 1'b1)
      finish_test;
endtask
// Pin reset alone, with a write refused meanwhile
task t_pin;
   pin_req = 1'b1;
   repeat (8) @(negedge clk);
   chk("core", 8'h00, {7'h00, core_n});
   chk("state", 8'h01, {7'h00, state});
   chk("test", 8'h01, {7'h00, test_n});
   wr = 1'b1;
   wd = 8'h01;
   @(negedge clk);
   wr = 1'b0;
   pin_req = 1'b0;
   repeat (16) @(negedge clk);
   chk("held", 8'h00, {7'h00, core_n});
   wait_core;
   repeat (2) @(negedge clk);
   chk("state", 8'h00, {7'h00, state});
   chk("pudr", 8'h00, pudr);
endtask
// Full reset: pin and test reset together
task t_full;
   pin_req = 1'b1;
   trst_req = 1'b1;
   repeat (8) @(negedge clk);
   chk("test", 8'h00, {7'h00, test_n});
   chk("core", 8'h00, {7'h00, core_n});
   pin_req = 1'b0;
   trst_req = 1'b0;
   wait_core;
   chk("test", 8'h01, {7'h00, test_n});
endtask
// Power-on reset with pin idle
task t_por;
   por_n = 1'b0;
   repeat (6) @(negedge clk);
   chk("core", 8'h00, {7'h00, core_n});
   por_n = 1'b1;
   repeat (20) @(negedge clk);
   chk("held", 8'h00, {7'h00, core_n});
   wait_core;
endtask
// Pull-up disable writes, back to back
task t_pud;
   wr = 1'b1;
   wd = 8'h01;
   @(negedge clk);
   wr = 1'b0;
   repeat (2) @(negedge clk);
   chk("pudr", 8'h01, pudr);
   chk("pu_en", 8'h00, {7'h00, pu_en});
   wr = 1'b1;
   wd = 8'hfe;
   @(negedge clk);
   wd = 8'h00;
   @(negedge clk);
   wr = 1'b0;
   chk("pudr", 8'hfe, pudr);
   repeat (2) @(negedge clk);
   chk("pudr", 8'h00, pudr);
   chk("pu_en", 8'h01, {7'h00, pu_en});
endtask
initial
begin
   repeat (10) @(negedge clk);
   rst_n = 1'b1;
   por_n = 1'b1;
   wait_core;
   chk("pu_en", 8'h01, {7'h00, pu_en});
   t_pin;
   t_full;
   t_por;
   t_pud;
   finish_test;
end
endmodule // testbench
